// *** verilog/a8t_pkg.sv ***
package a8t_pkg;
    // ==========================================================
    // register byte addresses
    localparam logic [7:0] CTRL_A_ADDR = 8'hb0;
    localparam logic [7:0] COUNTER_ADDR = 8'hb4;
    localparam logic [7:0] COMPARE_ADDR = 8'hb8;
    localparam logic [7:0] FLAGS_ADDR = 8'hbc;
    localparam logic [7:0] MASK_ADDR = 8'hc0;
    localparam logic [7:0] ASYNC_ADDR = 8'hc4;
    localparam logic [7:0] GENERAL_ADDR = 8'hc8;
    // ==========================================================
    // timer_control_a fields
    localparam int FORCE_BIT = 7;
    localparam int WGM0_BIT = 6;
    localparam int COM_HI_BIT = 5;
    localparam int COM_LO_BIT = 4;
    localparam int WGM1_BIT = 3;
    localparam int CS_HI_BIT = 2;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_A_RW_MASK = 8'h7f;
    // ==========================================================
    // flag, mask, async and general fields
    localparam int OVF_BIT = 0;
    localparam int CMP_BIT = 1;
    localparam int ASYNC_SEL_BIT = 3;
    localparam int PSR_BIT = 1;
    // ==========================================================
    // counter values
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX = 8'hff;
    // ==========================================================
    // prescaler divide masks
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV32_MASK = 10'h01f;
    localparam logic [9:0] DIV64_MASK = 10'h03f;
    localparam logic [9:0] DIV128_MASK = 10'h07f;
    localparam logic [9:0] DIV256_MASK = 10'h0ff;
    localparam logic [9:0] DIV1024_MASK = 10'h3ff;
    // ==========================================================
    // waveform modes
    typedef enum logic [1:0] {
        A8T_NORMAL = 2'b00,
        A8T_PHASE = 2'b01,
        A8T_CTC = 2'b10,
        A8T_FAST = 2'b11
    } a8t_mode_type;
endpackage

// *** verilog/a8t_timer.sv ***
`timescale 1ns/1ps
// Functional notes
// R1 - counter and compare are 8-bit read/write
// R2 - interrupt flags in one register, each masked
// R3 - no clock selected freezes the counter
// R4 - sync clock default; async select uses crystal
// R5 - compare double-buffered in pwm modes, compared every tick
// R6 - match sets compare flag, maskable request
// R7 - bottom 0x00, max 0xff, top per mode
// R8 - ticks: stop, source, /8 /32 /64 /128 /256 /1024
// R9 - prescaler reset bit restarts prescaler phase
// R10 - software writes force zero in pwm modes
// R11 - force strobe applies compare match to output
// R12 - force sets no flag, no clear
// R13 - force bit always reads zero
// R14 - two mode bits select four modes
// R15 - counter counts up and down by mode
// R16 - output gives pwm or square wave
// R17 - normal mode wraps, overflow when becoming zero
// R18 - ctc clears on the match tick
// R19 - non-pwm toggle setting toggles on match
// R20 - async mode counter and compare writes wait for timer clock edge
module a8t_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // crystal pins
    input wire logic crystal_in_pin_i,
    output logic crystal_out_pin_o,
    // compare output pin
    output logic compare_output_a_o,
    output logic compare_output_a_oe_o,
    // interrupt requests
    output logic compare_irq_o,
    output logic overflow_irq_o
);
    // ==========================================================
    // helpers
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction

    function automatic logic [9:0] div_mask(input logic [2:0] cs);
        unique case (cs)
            3'd2: div_mask = a8t_pkg::DIV8_MASK;
            3'd3: div_mask = a8t_pkg::DIV32_MASK;
            3'd4: div_mask = a8t_pkg::DIV64_MASK;
            3'd5: div_mask = a8t_pkg::DIV128_MASK;
            3'd6: div_mask = a8t_pkg::DIV256_MASK;
            3'd7: div_mask = a8t_pkg::DIV1024_MASK;
            default: div_mask = 10'h000;
        endcase
    endfunction

    // ==========================================================
    // state
    logic ack_q;
    logic [7:0] ctrl_q;
    logic [7:0] cnt_q;
    logic [7:0] ocr_buf_q;
    logic [7:0] ocr_act_q;
    logic [1:0] flag_q;
    logic [1:0] mask_q;
    logic async_q;
    logic [9:0] pre_q;
    logic xtal_q;
    logic xtal_prev_q;
    logic dir_up_q;
    logic block_q;
    logic pend_cnt_q;
    logic [7:0] pend_cnt_val_q;
    logic pend_ocr_q;
    logic [7:0] pend_ocr_val_q;
    logic out_q;
    logic oe_q;
    logic cmp_irq_q;
    logic ovf_irq_q;
    logic [31:0] dat_q;

    // ==========================================================
    // decode
    logic req;
    logic wr;
    logic wr_ctrl;
    logic wr_cnt;
    logic wr_ocr;
    logic wr_flag;
    logic wr_mask;
    logic wr_async;
    logic wr_gen;
    a8t_pkg::a8t_mode_type mode;
    logic [1:0] com;
    logic [2:0] cs;
    logic non_pwm;
    logic src_en;
    logic tick;
    logic match;
    logic overflow;
    logic force_cmp;
    logic cnt_load;
    logic [7:0] cnt_load_val;
    logic [7:0] top;
    logic at_bottom_next;

    assign req = cyc_i & stb_i & ~ack_q;
    assign wr = req & we_i & sel_i[0];
    assign wr_ctrl = wr & hit(adr_i, a8t_pkg::CTRL_A_ADDR);
    assign wr_cnt = wr & hit(adr_i, a8t_pkg::COUNTER_ADDR);
    assign wr_ocr = wr & hit(adr_i, a8t_pkg::COMPARE_ADDR);
    assign wr_flag = wr & hit(adr_i, a8t_pkg::FLAGS_ADDR);
    assign wr_mask = wr & hit(adr_i, a8t_pkg::MASK_ADDR);
    assign wr_async = wr & hit(adr_i, a8t_pkg::ASYNC_ADDR);
    assign wr_gen = wr & hit(adr_i, a8t_pkg::GENERAL_ADDR);

    assign mode = a8t_pkg::a8t_mode_type'({ctrl_q[a8t_pkg::WGM1_BIT],
                                           ctrl_q[a8t_pkg::WGM0_BIT]}); // [R14]
    assign com = ctrl_q[a8t_pkg::COM_HI_BIT:a8t_pkg::COM_LO_BIT];
    assign cs = ctrl_q[a8t_pkg::CS_HI_BIT:0];
    assign non_pwm = (mode == a8t_pkg::A8T_NORMAL) || (mode == a8t_pkg::A8T_CTC);

    // ==========================================================
    // clock source and prescaler
    // crystal edge acts as source clock enable in async mode
    assign src_en = async_q ? (xtal_q & ~xtal_prev_q) : 1'b1; // [R4]
    assign tick = src_en && (cs != 3'd0)
                  && ((pre_q & div_mask(cs)) == div_mask(cs)); // [R3] [R8]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xtal_q <= 1'b0;
            xtal_prev_q <= 1'b0;
            crystal_out_pin_o <= 1'b1;
        end else begin
            xtal_q <= crystal_in_pin_i;
            xtal_prev_q <= xtal_q;
            crystal_out_pin_o <= ~xtal_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= 10'h000;
        end else if (wr_gen && dat_i[a8t_pkg::PSR_BIT]) begin
            pre_q <= 10'h000; // [R9]
        end else if (src_en) begin
            pre_q <= pre_q + 10'h001;
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= a8t_pkg::CTRL_A_RESET;
            mask_q <= 2'b00;
            async_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= dat_i[7:0] & a8t_pkg::CTRL_A_RW_MASK; // [R13]
            end
            if (wr_mask) begin
                mask_q <= {dat_i[a8t_pkg::CMP_BIT], dat_i[a8t_pkg::OVF_BIT]}; // [R2]
            end
            if (wr_async) begin
                async_q <= dat_i[a8t_pkg::ASYNC_SEL_BIT]; // [R4]
            end
        end
    end

    // ==========================================================
    // pending writes for async mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_cnt_q <= 1'b0;
            pend_cnt_val_q <= 8'h00;
            pend_ocr_q <= 1'b0;
            pend_ocr_val_q <= 8'h00;
        end else begin
            if (wr_cnt && async_q) begin
                pend_cnt_q <= 1'b1; // [R20]
                pend_cnt_val_q <= dat_i[7:0];
            end else if (src_en) begin
                pend_cnt_q <= 1'b0;
            end
            if (wr_ocr && async_q) begin
                pend_ocr_q <= 1'b1; // [R20]
                pend_ocr_val_q <= dat_i[7:0];
            end else if (src_en) begin
                pend_ocr_q <= 1'b0;
            end
        end
    end

    assign cnt_load = (wr_cnt && !async_q) || (pend_cnt_q && src_en); // [R20]
    assign cnt_load_val = async_q ? pend_cnt_val_q : dat_i[7:0];

    // ==========================================================
    // compare register, double buffered in pwm modes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ocr_buf_q <= 8'h00;
        end else if (wr_ocr && !async_q) begin
            ocr_buf_q <= dat_i[7:0]; // [R1]
        end else if (pend_ocr_q && src_en) begin
            ocr_buf_q <= pend_ocr_val_q; // [R20]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ocr_act_q <= 8'h00;
        end else if (non_pwm) begin
            ocr_act_q <= ocr_buf_q; // [R5]
        end else if (tick && cnt_q == a8t_pkg::MAX
                     && (mode == a8t_pkg::A8T_FAST || dir_up_q)) begin
            ocr_act_q <= ocr_buf_q; // [R5] [R14]
        end
    end

    // ==========================================================
    // counter unit
    assign top = (mode == a8t_pkg::A8T_CTC) ? ocr_act_q : a8t_pkg::MAX; // [R7]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= a8t_pkg::BOTTOM;
            dir_up_q <= 1'b1;
        end else if (cnt_load) begin
            cnt_q <= cnt_load_val; // [R1]
        end else if (tick) begin
            unique case (mode)
                a8t_pkg::A8T_PHASE: begin
                    if (dir_up_q) begin
                        if (cnt_q == top) begin
                            dir_up_q <= 1'b0; // [R15]
                            cnt_q <= cnt_q - 8'h01;
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end else if (cnt_q == a8t_pkg::BOTTOM) begin
                        dir_up_q <= 1'b1;
                        cnt_q <= cnt_q + 8'h01;
                    end else begin
                        cnt_q <= cnt_q - 8'h01; // [R15]
                    end
                end
                a8t_pkg::A8T_CTC: begin
                    dir_up_q <= 1'b1;
                    if (cnt_q == top) begin
                        cnt_q <= a8t_pkg::BOTTOM; // [R18]
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                a8t_pkg::A8T_NORMAL, a8t_pkg::A8T_FAST: begin
                    dir_up_q <= 1'b1;
                    cnt_q <= cnt_q + 8'h01; // [R17]
                end
            endcase
        end
    end

    // a counter write blocks a match on the next tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            block_q <= 1'b0;
        end else if (cnt_load) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // ==========================================================
    // events and flags
    assign match = tick && !block_q && (cnt_q == ocr_act_q); // [R5]
    assign overflow = tick && ((mode == a8t_pkg::A8T_PHASE)
                               ? (!dir_up_q && cnt_q == 8'h01)
                               : (cnt_q == a8t_pkg::MAX)); // [R14] [R17]
    assign force_cmp = wr_ctrl && dat_i[a8t_pkg::FORCE_BIT] && non_pwm; // [R11]
    assign at_bottom_next = tick && cnt_q == a8t_pkg::MAX;

    // set wins over a clear-by-writing-one; force touches no flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 2'b00;
        end else begin
            flag_q[a8t_pkg::CMP_BIT] <= match || (flag_q[a8t_pkg::CMP_BIT]
                && !(wr_flag && dat_i[a8t_pkg::CMP_BIT])); // [R6] [R12]
            flag_q[a8t_pkg::OVF_BIT] <= overflow || (flag_q[a8t_pkg::OVF_BIT]
                && !(wr_flag && dat_i[a8t_pkg::OVF_BIT])); // [R17]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_irq_q <= 1'b0;
            ovf_irq_q <= 1'b0;
        end else begin
            cmp_irq_q <= flag_q[a8t_pkg::CMP_BIT] & mask_q[a8t_pkg::CMP_BIT]; // [R6] [R2]
            ovf_irq_q <= flag_q[a8t_pkg::OVF_BIT] & mask_q[a8t_pkg::OVF_BIT]; // [R2]
        end
    end

    // ==========================================================
    // waveform generator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            oe_q <= (com != 2'b00);
            if (non_pwm) begin
                if (match || force_cmp) begin // [R11] [R16]
                    unique case (com)
                        2'b01: out_q <= ~out_q; // [R19]
                        2'b10: out_q <= 1'b0;
                        2'b11: out_q <= 1'b1;
                        default: out_q <= out_q;
                    endcase
                end
            end else if (mode == a8t_pkg::A8T_FAST) begin
                if (match && com[1]) begin
                    out_q <= com[0]; // [R16]
                end else if (at_bottom_next && com[1]) begin
                    out_q <= ~com[0];
                end
            end else if (match && com[1]) begin
                out_q <= com[0] ^ ~dir_up_q; // [R16]
            end
        end
    end

    assign compare_output_a_o = out_q;
    assign compare_output_a_oe_o = oe_q;
    assign compare_irq_o = cmp_irq_q;
    assign overflow_irq_o = ovf_irq_q;

    // ==========================================================
    // wishbone answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req && !we_i) begin
                if (hit(adr_i, a8t_pkg::CTRL_A_ADDR)) begin
                    dat_q <= {24'h000000, ctrl_q & a8t_pkg::CTRL_A_RW_MASK}; // [R13]
                end else if (hit(adr_i, a8t_pkg::COUNTER_ADDR)) begin
                    dat_q <= {24'h000000, cnt_q}; // [R1]
                end else if (hit(adr_i, a8t_pkg::COMPARE_ADDR)) begin
                    dat_q <= {24'h000000, ocr_buf_q};
                end else if (hit(adr_i, a8t_pkg::FLAGS_ADDR)) begin
                    dat_q <= {30'h00000000, flag_q};
                end else if (hit(adr_i, a8t_pkg::MASK_ADDR)) begin
                    dat_q <= {30'h00000000, mask_q};
                end else if (hit(adr_i, a8t_pkg::ASYNC_ADDR)) begin
                    dat_q <= {28'h0000000, async_q, 3'h0};
                end else begin
                    dat_q <= 32'h0000_0000;
                end
            end else begin
                dat_q <= 32'h0000_0000;
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;
endmodule

// *** testbench/a8t_timer_assertions.sv ***
`timescale 1ns/1ps
module a8t_timer_assertions (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // pins and requests
    input wire logic crystal_in_pin_i,
    input wire logic crystal_out_pin_o,
    input wire logic compare_output_a_o,
    input wire logic compare_output_a_oe_o,
    input wire logic compare_irq_o,
    input wire logic overflow_irq_o
);
    // ==========================================================
    // shadow of mode and mask bits
    logic [1:0] com_q;
    logic [1:0] mask_q;
    logic wr_take;
    assign wr_take = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            com_q <= 2'h0;
            mask_q <= 2'h0;
        end else begin
            if (wr_take && adr_i == a8t_pkg::CTRL_A_ADDR) begin
                com_q <= dat_i[5:4];
            end
            if (wr_take && adr_i == a8t_pkg::MASK_ADDR) begin
                mask_q <= dat_i[1:0];
            end
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    chk_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing after request");
    chk_ack_one_cycle: assert property (ack_o |-> ##1 !ack_o)
        else $error("ack longer than one cycle");
    chk_ack_no_req: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    chk_idle_data_zero: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    chk_upper_bits_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_force_reads_zero: assert property (ack_o && !$past(we_i)
        && $past(adr_i) == a8t_pkg::CTRL_A_ADDR |-> !dat_o[7])
        else $error("force bit read as one");
    chk_unmapped_zero: assert property (ack_o && !$past(we_i)
        && ($past(adr_i) < 8'hb0 || $past(adr_i) > 8'hcb) |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_oe_tracks_mode: assert property (compare_output_a_oe_o == ($past(com_q) != 2'h0))
        else $error("output enable wrong");
    chk_cmp_irq_gated: assert property (!$past(mask_q[1]) |-> !compare_irq_o)
        else $error("compare request not masked");
    chk_ovf_irq_gated: assert property (!$past(mask_q[0]) |-> !overflow_irq_o)
        else $error("overflow request not masked");
    chk_xtal_out_inverse: assert property (crystal_out_pin_o == !$past(crystal_in_pin_i, 2))
        else $error("crystal output not inverse of input");
    cover property (compare_irq_o);
    cover property (overflow_irq_o);
    cover property ($rose(compare_output_a_o));
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    // ==========================================================
    // signals
    localparam logic [7:0] CT = a8t_pkg::CTRL_A_ADDR;
    localparam logic [7:0] CN = a8t_pkg::COUNTER_ADDR;
    localparam logic [7:0] CP = a8t_pkg::COMPARE_ADDR;
    localparam logic [7:0] FL = a8t_pkg::FLAGS_ADDR;
    localparam logic [7:0] MK = a8t_pkg::MASK_ADDR;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0;
    logic crystal_in_pin_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o, crystal_out_pin_o, compare_output_a_o, compare_output_a_oe_o;
    logic compare_irq_o, overflow_irq_o;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic xtal_run = 1'b0;
    logic [1:0] xdiv = 2'h0;
    logic [31:0] seed = 32'h509e;
    logic p;
    int t1, t2;
    int divs [7] = '{1, 8, 32, 64, 128, 256, 1024};
    logic [7:0] regs [7] = '{8'hb0, 8'hb4, 8'hb8, 8'hbc, 8'hc0, 8'hc4, 8'hc8};
    logic [7:0] mctl [4] = '{8'h11, 8'h19, 8'h69, 8'h61};
    int msum [4] = '{512, 34, 256, 510};
    always #2.5 clk_i = ~clk_i;
    a8t_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .crystal_in_pin_i(crystal_in_pin_i),
        .crystal_out_pin_o(crystal_out_pin_o), .compare_output_a_o(compare_output_a_o),
        .compare_output_a_oe_o(compare_output_a_oe_o), .compare_irq_o(compare_irq_o),
        .overflow_irq_o(overflow_irq_o));
    // ==========================================================
    // timeout and crystal
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end
    always @(posedge clk_i) begin
        if (xtal_run) begin
            xdiv <= (xdiv == 2'h2) ? 2'h0 : xdiv + 2'h1;
            if (xdiv == 2'h2) begin
                crystal_in_pin_i <= ~crystal_in_pin_i;
            end
        end
    end
    // ==========================================================
    // tasks
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_sim();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rng(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("[FAIL] %0t interval %0d expected %0d", $time, got, lo);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        cmp_val({24'h0, q}, {24'h0, e});
    endtask
    task automatic meas(output int a, output int b);
        int n;
        @(negedge clk_i);
        p = compare_output_a_o;
        for (n = 0; compare_output_a_o === p && n < 3000; n++) @(negedge clk_i);
        p = compare_output_a_o;
        for (a = 0; compare_output_a_o === p && a < 3000; a++) @(negedge clk_i);
        p = compare_output_a_o;
        for (b = 0; compare_output_a_o === p && b < 3000; b++) @(negedge clk_i);
        @(posedge clk_i);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 7; i++) rd_chk(regs[i], 8'h00);
        wr(8'hcc, 8'hff);
        rd_chk(8'hcc, 8'h00);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(CN, seed[7:0]);
            wr(CP, seed[15:8]);
            repeat (20) @(posedge clk_i);
            rd_chk(CN, seed[7:0]);
            rd_chk(CP, seed[15:8]);
        end
        wr(CT, 8'h7f);
        rd_chk(CT, 8'h7f);
        wr(CT, 8'h00);
        wr(CN, 8'h05);
        wr(FL, 8'h03);
        wr(CT, 8'h18);
        p = compare_output_a_o;
        wr(CT, 8'h98);
        cmp_val({31'h0, compare_output_a_o}, {31'h0, ~p});
        rd_chk(CT, 8'h18);
        rd_chk(CN, 8'h05);
        rd_chk(FL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(CT, 8'h00);
            wr(CP, 8'h10);
            wr(CT, mctl[i]);
            repeat (520) @(posedge clk_i);
            meas(t1, t2);
            cmp_rng(t1 + t2, msum[i], msum[i]);
        end
        wr(CT, 8'h00);
        wr(CP, 8'h00);
        wr(CN, 8'h00);
        wr(a8t_pkg::GENERAL_ADDR, 8'h02);
        rd_chk(a8t_pkg::GENERAL_ADDR, 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr(CT, 8'h18 | 8'(i + 1));
            meas(t1, t2);
            cmp_rng(t1, divs[i], divs[i]);
        end
        wr(CT, 8'h01);
        wr(MK, 8'h03);
        wr(FL, 8'h03);
        repeat (300) @(posedge clk_i);
        rd_chk(FL, 8'h03);
        cmp_val({30'h0, compare_irq_o, overflow_irq_o}, 32'h3);
        wr(MK, 8'h00);
        cmp_val({30'h0, compare_irq_o, overflow_irq_o}, 32'h0);
        wr(CT, 8'h00);
        wr(FL, 8'h03);
        rd_chk(FL, 8'h00);
        wr(a8t_pkg::ASYNC_ADDR, 8'h08);
        wr(CT, 8'h19);
        p = compare_output_a_o;
        repeat (40) @(posedge clk_i);
        cmp_val({31'h0, compare_output_a_o}, {31'h0, p});
        xtal_run <= 1'b1;
        meas(t1, t2);
        cmp_rng(t1, 6, 6);
        wr(CP, 8'h02);
        repeat (40) @(posedge clk_i);
        meas(t1, t2);
        cmp_rng(t1, 18, 18);
        end_sim();
    end
endmodule
bind a8t_timer a8t_timer_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .crystal_in_pin_i(crystal_in_pin_i),
    .crystal_out_pin_o(crystal_out_pin_o), .compare_output_a_o(compare_output_a_o),
    .compare_output_a_oe_o(compare_output_a_oe_o), .compare_irq_o(compare_irq_o),
    .overflow_irq_o(overflow_irq_o));
